// >>> src/ucm_pkg.sv
package ucm_pkg;

  // ==========================================================================
  // Register map: channel select bit and word offsets inside a channel.
  // ==========================================================================
  localparam int       FIFO_DEPTH_DEF = 8;
  localparam int       CHAN_BIT       = 4;
  localparam bit [3:0] OFS_MODE       = 4'h0;
  localparam bit [3:0] OFS_STATUS     = 4'h4;
  localparam bit [3:0] OFS_CMD        = 4'h8;
  localparam bit [3:0] OFS_BUF        = 4'hc;
  localparam bit [7:0] MODE_RST       = 8'h00;
  localparam bit [7:0] MR0_MASK_A     = 8'hf7;
  localparam bit [7:0] MR0_MASK_B     = 8'hf0;

  // ==========================================================================
  // Field positions of the three mode registers and the command register.
  // ==========================================================================
  localparam int MR0_EXT1 = 0;
  localparam int MR0_TEST = 1;
  localparam int MR0_EXT2 = 2;
  localparam int MR0_TXTL = 4;
  localparam int MR0_RXTL = 6;
  localparam int MR0_WDOG = 7;
  localparam int MR1_LEN  = 0;
  localparam int MR1_PTYP = 2;
  localparam int MR1_PMOD = 3;
  localparam int MR1_ERRM = 5;
  localparam int MR1_RXTL = 6;
  localparam int MR1_RRTS = 7;
  localparam int MR2_STOP = 0;
  localparam int MR2_CTS  = 4;
  localparam int MR2_TRTS = 5;
  localparam int MR2_LOOP = 6;
  localparam bit [1:0] EN_ON  = 2'b01;
  localparam bit [1:0] EN_OFF = 2'b10;
  localparam bit [3:0] CMD_PTR1    = 4'h1;
  localparam bit [3:0] CMD_RST_RX  = 4'h2;
  localparam bit [3:0] CMD_RST_TX  = 4'h3;
  localparam bit [3:0] CMD_CLR_ERR = 4'h4;
  localparam bit [3:0] CMD_RTS_ON  = 4'h8;
  localparam bit [3:0] CMD_RTS_OFF = 4'h9;
  localparam bit [3:0] CMD_PTR0    = 4'hb;
  localparam bit [1:0] PM_WITH  = 2'b00;
  localparam bit [1:0] PM_FORCE = 2'b01;
  localparam bit [1:0] PM_NONE  = 2'b10;
  localparam bit [1:0] PM_MDROP = 2'b11;

  // Trigger levels indexed by the two-bit select code, entry 0 first.
  localparam bit [0:3][4:0] TX_LVL8  = '{5'h08, 5'h04, 5'h06, 5'h01};
  localparam bit [0:3][4:0] TX_LVL16 = '{5'h10, 5'h06, 5'h0c, 5'h01};
  localparam bit [0:3][4:0] RX_LVL8  = '{5'h01, 5'h03, 5'h06, 5'h08};
  localparam bit [0:3][4:0] RX_LVL16 = '{5'h01, 5'h06, 5'h0c, 5'h10};

  typedef enum logic [2:0] {PTR0 = 3'b001, PTR1 = 3'b010, PTR2 = 3'b100} ucm_ptr_t;

  // One character event from the receive shifter, plus line state.
  typedef struct packed {
    logic       push;
    logic       start;
    logic       held;
    logic       line_mark;
    logic [7:0] data;
    logic       stop_ok;
    logic       any_one;
    logic       parity_bad;
    logic       tag;
  } ucm_rx_evt_t;

  typedef struct packed {
    logic pop;
    logic idle;
  } ucm_tx_evt_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ucm_tx_push_t;

  typedef struct packed {
    logic       baud_ext1;
    logic       baud_ext2;
    logic       test_mode;
    logic       rx_timeout_en;
    logic [1:0] char_len;
    logic       parity_type;
    logic [1:0] parity_mode;
    logic       error_mode;
    logic [3:0] stop_len;
    logic [1:0] loop_mode;
    logic       rx_en;
    logic       tx_en;
    logic       tx_allow;
    logic       rx_trig;
    logic       tx_trig;
  } ucm_cfg_t;

endpackage

// >>> src/ucm_chan_status.sv
`timescale 1ns/1ns
module ucm_chan_status #(
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  ucm_pkg::ucm_rx_evt_t      rx_evt,
  input  ucm_pkg::ucm_tx_evt_t      tx_evt,
  input  wire logic                 host_rd,
  input  wire logic                 host_wr,
  input  wire logic                 flush_rx,
  input  wire logic                 flush_tx,
  input  wire logic                 clr_err,
  input  wire logic                 tx_en,
  input  wire logic                 blk_mode,
  input  wire logic [1:0]           par_mode,
  output logic      [7:0]           status,
  output logic      [7:0]           rx_head,
  output logic      [CW-1:0]        rx_cnt,
  output logic      [CW-1:0]        tx_cnt
);
  import ucm_pkg::*;

  // Pointers wrap by overflow, so DEPTH must be a power of two.
  localparam int AW = $clog2(DEPTH);

  logic [7:0]    dat_mem [DEPTH];
  logic [2:0]    st_mem  [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic          brk_inh;
  logic          ovr;
  logic          tx_empty;
  logic [2:0]    acc;
  logic [2:0]    st_in;
  logic [2:0]    st_head;
  logic [2:0]    err;
  logic          is_brk;
  logic          pe_now;
  logic          push;
  logic          pop;
  logic          rx_full;

  // ==========================================================================
  // Receive character classification.
  // ==========================================================================
  assign rx_full = rx_cnt == CW'(DEPTH);
  assign is_brk  = !rx_evt.stop_ok && !rx_evt.any_one;
  assign pe_now  = (par_mode == PM_MDROP) ? rx_evt.tag :
                   rx_evt.parity_bad && (par_mode == PM_WITH || par_mode == PM_FORCE);
  assign st_in   = {is_brk, !rx_evt.stop_ok && rx_evt.any_one, pe_now};
  // A long break takes one entry only; repeats wait for the marking line.
  assign push    = rx_evt.push && !rx_full && !(is_brk && brk_inh);
  assign pop     = host_rd && rx_cnt != '0;

  // Storage has no reset; only the pointers and count define validity.
  always_ff @(posedge clk) begin
    if (push) begin
      dat_mem[wp] <= rx_evt.data;
      st_mem[wp]  <= st_in;
    end
  end

  // Pointers and occupancy of the receive FIFO.
  always_ff @(posedge clk) begin
    if (!nrst || flush_rx) begin
      wp     <= '0;
      rp     <= '0;
      rx_cnt <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      if (push && !pop) rx_cnt <= rx_cnt + 1'b1;
      else if (pop && !push) rx_cnt <= rx_cnt - 1'b1;
    end
  end

  // Break inhibit; a new break wins over the return to marking.
  always_ff @(posedge clk) begin
    if (!nrst) brk_inh <= 1'b0;
    else if (push && is_brk) brk_inh <= 1'b1;
    else if (rx_evt.line_mark) brk_inh <= 1'b0;
  end

  // Overrun is sticky until the reset-error command; a new event wins.
  always_ff @(posedge clk) begin
    if (!nrst) ovr <= 1'b0;
    else if (rx_evt.start && rx_full && rx_evt.held) ovr <= 1'b1;
    else if (clr_err) ovr <= 1'b0;
  end

  // Accumulated error bits for block mode.
  always_ff @(posedge clk) begin
    if (!nrst) acc <= '0;
    else if (push) acc <= acc | st_in;
    else if (clr_err) acc <= '0;
  end

  // Transmit FIFO occupancy; the data itself lives in the transmitter.
  always_ff @(posedge clk) begin
    if (!nrst || flush_tx) tx_cnt <= '0;
    else if (host_wr && tx_cnt != CW'(DEPTH) && !(tx_evt.pop && tx_cnt != '0))
      tx_cnt <= tx_cnt + 1'b1;
    else if (tx_evt.pop && tx_cnt != '0 && !(host_wr && tx_cnt != CW'(DEPTH)))
      tx_cnt <= tx_cnt - 1'b1;
  end

  // Transmit empty; the idle event wins over a disable in the same cycle.
  always_ff @(posedge clk) begin
    if (!nrst) tx_empty <= 1'b0;
    else if (tx_evt.idle && tx_cnt == '0 && !host_wr) tx_empty <= 1'b1;
    else if (host_wr || !tx_en) tx_empty <= 1'b0;
  end

  // ==========================================================================
  // Status byte as software sees it.
  // ==========================================================================
  assign st_head = st_mem[rp];
  assign rx_head = dat_mem[rp];
  assign err     = blk_mode ? acc : st_head;
  assign status  = {err[2], err[1], (par_mode == PM_MDROP) ? st_head[0] : err[0], ovr,
                    tx_empty, tx_en && tx_cnt != CW'(DEPTH), rx_full, rx_cnt != '0};

endmodule // ucm_chan_status

// >>> src/ucm_mode_status.sv
`timescale 1ns/1ns
// Functional notes
// - Mode registers follow a pointer: command B selects 0, reset or 1 select 1.
// - Channel A mode 0 bits 0 and 2 pick extended baud tables for both channels.
// - Unused mode 0 bits ignore writes: bit 3 on A, bits 3..0 on B.
// - Eight-deep transmit trigger codes give 8, 4, 6, 1 empty locations.
// - Sixteen-deep transmit trigger codes give 16, 6, 12, 1 empty locations.
// - Mode 0 bit 7 enables the receive timeout function; off after reset.
// - Mode 1 bit 2 is parity sense, or the sent tag in multidrop.
// - Mode 1 bits 4..3: with, forced, no parity, or multidrop.
// - Mode 1 bit 5 picks per-character or accumulated error reporting.
// - Auto receive or transmit RTS drives the channel's active-low RTS output.
// - Mode 2 bits 3..0 set stop length in sixteenths of a bit.
// - Mode 2 bit 4 lets CTS gate the transmitter; off after reset.
// - Mode 2 bits 7..6 pick none, echo, local or remote loopback.
// - Receive ready sets on first character, clears when FIFO read empty.
// - FIFO full sets when filled; any read clears it, since a push is blocked while full.
// - Transmit ready is high while the transmitter is enabled and its FIFO has room.
// - Transmit empty sets after last stop bit; write or disable clears.
// - Overrun sets on start bit with full FIFO and waiting character.
// - Parity error in parity modes; in multidrop the bit holds the tag.
// - Framing error when stop sample is low and any bit was one.
// - A break takes one FIFO entry; more wait for a marking line.
module ucm_mode_status #(
  parameter int DEPTH = ucm_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  NRST,
  input  wire logic [4:0]            AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  output logic      [31:0]           AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  ucm_pkg::ucm_rx_evt_t       RX_EVT_A,
  input  ucm_pkg::ucm_rx_evt_t       RX_EVT_B,
  input  ucm_pkg::ucm_tx_evt_t       TX_EVT_A,
  input  ucm_pkg::ucm_tx_evt_t       TX_EVT_B,
  input  wire logic                  CTS_N_A,
  input  wire logic                  CTS_N_B,
  output ucm_pkg::ucm_tx_push_t      TX_PUSH_A,
  output ucm_pkg::ucm_tx_push_t      TX_PUSH_B,
  output ucm_pkg::ucm_cfg_t          CFG_A,
  output ucm_pkg::ucm_cfg_t          CFG_B,
  output logic                       GENERAL_OUTPUT_ZERO_N,
  output logic                       GENERAL_OUTPUT_ONE_N
);
  import ucm_pkg::*;

  localparam int CW = $clog2(DEPTH) + 1;

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic          wait_req;
  logic [31:0]   rd_data;
  logic [31:0]   next_rd_data;
  logic          go;
  logic          wr_ok;
  logic          chan;
  logic [3:0]    sub;
  logic [3:0]    misc;
  logic [7:0]    mr0     [2];
  logic [7:0]    mr1     [2];
  logic [7:0]    mr2     [2];
  ucm_ptr_t      ptr     [2];
  logic          rx_en   [2];
  logic          tx_en   [2];
  logic          rts_n   [2];
  ucm_cfg_t      cfg     [2];
  ucm_tx_push_t  tx_push [2];
  ucm_rx_evt_t   rx_evt  [2];
  ucm_tx_evt_t   tx_evt  [2];
  logic          cts_n   [2];
  logic [7:0]    status  [2];
  logic [7:0]    rx_head [2];
  logic [CW-1:0] rx_cnt  [2];
  logic [CW-1:0] tx_cnt  [2];
  logic          sel     [2];
  logic          mode_acc[2];
  logic          cmd_wr  [2];
  logic          host_rd [2];
  logic          host_wr [2];
  logic          flush_rx[2];
  logic          flush_tx[2];
  logic          clr_err [2];

  // ==========================================================================
  // Bus slave handshake.
  // ==========================================================================
  // A request is acted on at the first edge that sees it with waitrequest high;
  // waitrequest then drops for one cycle so the master samples the answer.
  assign go    = (AVS_READ || AVS_WRITE) && wait_req;
  assign wr_ok = AVS_WRITE && AVS_BYTEENABLE[0];
  assign chan  = AVS_ADDRESS[CHAN_BIT];
  assign sub   = AVS_ADDRESS[3:0];
  assign misc  = AVS_WRITEDATA[7:4];

  assign AVS_WAITREQUEST = wait_req;
  assign AVS_READDATA    = rd_data;

  // Waitrequest toggles low for exactly one cycle per request.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) wait_req <= 1'b1;
    else if (go) wait_req <= 1'b0;
    else wait_req <= 1'b1;
  end

  // Read data is captured at the acting edge and held until the next read.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) rd_data <= '0;
    else if (go && AVS_READ) rd_data <= next_rd_data;
  end

  // Per-channel access strobes, all qualified by the acting edge.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      sel[c]      = go && (chan == c[0]);
      mode_acc[c] = sel[c] && sub == OFS_MODE && (AVS_READ || wr_ok);
      cmd_wr[c]   = sel[c] && sub == OFS_CMD && wr_ok;
      host_rd[c]  = sel[c] && sub == OFS_BUF && AVS_READ;
      host_wr[c]  = sel[c] && sub == OFS_BUF && wr_ok;
      flush_rx[c] = cmd_wr[c] && misc == CMD_RST_RX;
      flush_tx[c] = cmd_wr[c] && misc == CMD_RST_TX;
      clr_err[c]  = cmd_wr[c] && misc == CMD_CLR_ERR;
    end
  end

  // Read decode; reserved and misaligned offsets read as zero.
  always_comb begin
    next_rd_data = '0;
    if (sub == OFS_MODE) begin
      case (ptr[chan])
        PTR0:    next_rd_data[7:0] = mr0[chan];
        PTR1:    next_rd_data[7:0] = mr1[chan];
        PTR2:    next_rd_data[7:0] = mr2[chan];
        default: next_rd_data[7:0] = 8'h00;
      endcase
    end else if (sub == OFS_STATUS) begin
      next_rd_data[7:0] = status[chan];
    end else if (sub == OFS_BUF) begin
      next_rd_data[7:0] = rx_head[chan];
    end
  end

  // ==========================================================================
  // Mode registers and their pointer.
  // ==========================================================================
  // Writes land in the register the pointer names; channel B has no baud bits.
  always_ff @(posedge SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!NRST) begin
        mr0[c] <= MODE_RST;
        mr1[c] <= MODE_RST;
        mr2[c] <= MODE_RST;
      end else if (mode_acc[c] && AVS_WRITE) begin
        case (ptr[c])
          PTR0: mr0[c] <= AVS_WRITEDATA[7:0] & ((c == 0) ? MR0_MASK_A : MR0_MASK_B);
          PTR1: mr1[c] <= AVS_WRITEDATA[7:0];
          PTR2: mr2[c] <= AVS_WRITEDATA[7:0];
          default: mr2[c] <= mr2[c];
        endcase
      end
    end
  end

  // Pointer walks 0 to 1 to 2 on any access and parks at 2.
  always_ff @(posedge SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!NRST) ptr[c] <= PTR1;
      else if (cmd_wr[c] && misc == CMD_PTR0) ptr[c] <= PTR0;
      else if (cmd_wr[c] && misc == CMD_PTR1) ptr[c] <= PTR1;
      else if (mode_acc[c]) begin
        case (ptr[c])
          PTR0:    ptr[c] <= PTR1;
          PTR1:    ptr[c] <= PTR2;
          PTR2:    ptr[c] <= PTR2;
          default: ptr[c] <= PTR1;
        endcase
      end
    end
  end

  // ==========================================================================
  // Commands: enables and flow-control output.
  // ==========================================================================
  // Resetting a side also disables it; enable and disable bits are exclusive.
  always_ff @(posedge SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!NRST) begin
        rx_en[c] <= 1'b0;
        tx_en[c] <= 1'b0;
      end else if (cmd_wr[c]) begin
        if (flush_rx[c] || AVS_WRITEDATA[1:0] == EN_OFF) rx_en[c] <= 1'b0;
        else if (AVS_WRITEDATA[1:0] == EN_ON) rx_en[c] <= 1'b1;
        if (flush_tx[c] || AVS_WRITEDATA[3:2] == EN_OFF) tx_en[c] <= 1'b0;
        else if (AVS_WRITEDATA[3:2] == EN_ON) tx_en[c] <= 1'b1;
      end
    end
  end

  // Active-low RTS: manual commands first, then automatic receive mode, then automatic transmit mode.
  // Receive mode drops RTS while the FIFO is full and raises it once drained;
  // transmit mode holds RTS while data is queued and releases it when empty.
  always_ff @(posedge SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!NRST) rts_n[c] <= 1'b1;
      else if (cmd_wr[c] && misc == CMD_RTS_ON) rts_n[c] <= 1'b0;
      else if (cmd_wr[c] && misc == CMD_RTS_OFF) rts_n[c] <= 1'b1;
      else if (mr1[c][MR1_RRTS]) begin
        if (rx_cnt[c] == CW'(DEPTH)) rts_n[c] <= 1'b1;
        else if (rx_cnt[c] == '0) rts_n[c] <= 1'b0;
      end else if (mr2[c][MR2_TRTS]) begin
        if (tx_cnt[c] != '0) rts_n[c] <= 1'b0;
        else if (status[c][3]) rts_n[c] <= 1'b1;
      end
    end
  end

  assign GENERAL_OUTPUT_ZERO_N = rts_n[0];
  assign GENERAL_OUTPUT_ONE_N  = rts_n[1];

  // ==========================================================================
  // Transmit data hand-off to the transmitter's FIFO.
  // ==========================================================================
  // A write into a full FIFO is dropped, as the transmitter has no room.
  always_ff @(posedge SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!NRST) tx_push[c] <= '0;
      else begin
        tx_push[c].valid <= host_wr[c] && tx_cnt[c] != CW'(DEPTH);
        if (host_wr[c]) tx_push[c].data <= AVS_WRITEDATA[7:0];
      end
    end
  end

  assign TX_PUSH_A = tx_push[0];
  assign TX_PUSH_B = tx_push[1];

  // ==========================================================================
  // Configuration outputs to the serial engines, registered once.
  // ==========================================================================
  // The trigger flags lag the counts by one cycle, traded for clean outputs.
  always_ff @(posedge SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!NRST) cfg[c] <= '0;
      else begin
        cfg[c].baud_ext1     <= mr0[0][MR0_EXT1];
        cfg[c].baud_ext2     <= mr0[0][MR0_EXT2];
        cfg[c].test_mode     <= mr0[0][MR0_TEST];
        cfg[c].rx_timeout_en <= mr0[c][MR0_WDOG];
        cfg[c].char_len      <= mr1[c][MR1_LEN +: 2];
        cfg[c].parity_type   <= mr1[c][MR1_PTYP];
        cfg[c].parity_mode   <= mr1[c][MR1_PMOD +: 2];
        cfg[c].error_mode    <= mr1[c][MR1_ERRM];
        cfg[c].stop_len      <= mr2[c][MR2_STOP +: 4];
        cfg[c].loop_mode     <= mr2[c][MR2_LOOP +: 2];
        cfg[c].rx_en         <= rx_en[c];
        cfg[c].tx_en         <= tx_en[c];
        cfg[c].tx_allow      <= tx_en[c] && (!mr2[c][MR2_CTS] || !cts_n[c]);
        if (DEPTH == 16) begin
          cfg[c].rx_trig <= rx_cnt[c] >= CW'(RX_LVL16[{mr0[c][MR0_RXTL], mr1[c][MR1_RXTL]}]);
          cfg[c].tx_trig <= CW'(DEPTH) - tx_cnt[c] >=
                            CW'(TX_LVL16[mr0[c][MR0_TXTL +: 2]]);
        end else begin
          cfg[c].rx_trig <= rx_cnt[c] >=
                            CW'(RX_LVL8[{mr0[c][MR0_RXTL], mr1[c][MR1_RXTL]}]);
          cfg[c].tx_trig <= CW'(DEPTH) - tx_cnt[c] >= CW'(TX_LVL8[mr0[c][MR0_TXTL +: 2]]);
        end
      end
    end
  end

  assign CFG_A = cfg[0];
  assign CFG_B = cfg[1];

  // ==========================================================================
  // Per-channel receive FIFO and status flags.
  // ==========================================================================
  assign rx_evt[0] = RX_EVT_A;
  assign rx_evt[1] = RX_EVT_B;
  assign tx_evt[0] = TX_EVT_A;
  assign tx_evt[1] = TX_EVT_B;
  assign cts_n[0]  = CTS_N_A;
  assign cts_n[1]  = CTS_N_B;

  for (genvar g = 0; g < 2; g++) begin : g_chan
    ucm_chan_status #(
      .DEPTH (DEPTH),
      .CW    (CW)
    ) u_stat (
      .clk      (SYS_CLK),
      .nrst     (NRST),
      .rx_evt   (rx_evt[g]),
      .tx_evt   (tx_evt[g]),
      .host_rd  (host_rd[g]),
      .host_wr  (host_wr[g]),
      .flush_rx (flush_rx[g]),
      .flush_tx (flush_tx[g]),
      .clr_err  (clr_err[g]),
      .tx_en    (tx_en[g]),
      .blk_mode (mr1[g][MR1_ERRM]),
      .par_mode (mr1[g][MR1_PMOD +: 2]),
      .status   (status[g]),
      .rx_head  (rx_head[g]),
      .rx_cnt   (rx_cnt[g]),
      .tx_cnt   (tx_cnt[g])
    );
  end

endmodule // ucm_mode_status

// >>> bench/ucm_far_end.sv
`timescale 1ns/1ns
// ==========================================================================
// Far-side model: the channel A receiver and transmitter engines.
module ucm_far_end (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             send,
  input  wire logic [7:0]       send_data,
  input  ucm_pkg::ucm_tx_push_t push_in,
  output ucm_pkg::ucm_rx_evt_t  rx_evt,
  output ucm_pkg::ucm_tx_evt_t  tx_evt
);
  import ucm_pkg::*;
  logic [3:0] dly;
  // One clean character per cycle while send is high; the line rests marking.
  always_ff @(posedge clk) begin
    rx_evt <= '0;
    rx_evt.line_mark <= 1'b1;
    if (send) begin
      rx_evt.push <= 1'b1;
      rx_evt.start <= 1'b1;
      rx_evt.data <= send_data;
      rx_evt.stop_ok <= 1'b1;
      rx_evt.any_one <= |send_data;
    end
  end
  // The shifter is slow on purpose, so empty is seen late, not at the write.
  always_ff @(posedge clk) begin
    tx_evt <= '0;
    if (!nrst) begin
      dly <= 4'h0;
    end else if (push_in.valid) begin
      dly <= 4'h1;
    end else if (dly != 4'h0) begin
      dly <= (dly == 4'hc) ? 4'h0 : dly + 4'h1;
    end
    tx_evt.pop <= (dly == 4'h4);
    tx_evt.idle <= (dly == 4'hc);
  end
endmodule // ucm_far_end

// >>> bench/ucm_mode_status_assertions.sv
`timescale 1ns/1ns
// ==========================================================================
// Port checker for the mode and status block.
module ucm_chk (
  input wire logic             SYS_CLK,
  input wire logic             NRST,
  input wire logic             AVS_READ,
  input wire logic             AVS_WRITE,
  input wire logic [4:0]       AVS_ADDRESS,
  input wire logic             AVS_WAITREQUEST,
  input ucm_pkg::ucm_tx_push_t TX_PUSH_A,
  input ucm_pkg::ucm_cfg_t     CFG_A,
  input ucm_pkg::ucm_cfg_t     CFG_B
);
  import ucm_pkg::*;
  // Config lags a write by a cycle, so $past still sees the held request.
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  property p_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1
    AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one cycle");
  property p_pulse; TX_PUSH_A.valid |=> !TX_PUSH_A.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("push longer than a cycle");
  property p_push; TX_PUSH_A.valid |-> $past(AVS_WRITE) && $past(AVS_ADDRESS) == 5'h0c; endproperty
  a_push: assert property (p_push) else $error("push without buffer write");
  property p_ext; CFG_A.baud_ext1 == CFG_B.baud_ext1 &&
    CFG_A.baud_ext2 == CFG_B.baud_ext2; endproperty
  a_ext: assert property (p_ext) else $error("baud table differs");
  property p_loop; $changed(CFG_A.loop_mode) |-> $past(AVS_WRITE); endproperty
  a_loop: assert property (p_loop) else $error("loop mode moved");
  property p_stop; !$past(AVS_WRITE) |-> $stable(CFG_A.stop_len); endproperty
  a_stop: assert property (p_stop) else $error("stop length moved");
  property p_len; $changed(CFG_A.char_len) |-> $past(AVS_ADDRESS) == 5'h00; endproperty
  a_len: assert property (p_len) else $error("length moved");
  property p_wd; $rose(CFG_A.rx_timeout_en) |-> $past(AVS_WRITE); endproperty
  a_wd: assert property (p_wd) else $error("timeout enable rose");
  property p_cts; CFG_A.tx_allow |-> CFG_A.tx_en; endproperty
  a_cts: assert property (p_cts) else $error("allow while disabled");
endmodule // ucm_chk
bind ucm_mode_status ucm_chk ucm_chk_inst (.SYS_CLK(SYS_CLK), .NRST(NRST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TX_PUSH_A(TX_PUSH_A), .CFG_A(CFG_A), .CFG_B(CFG_B));

// >>> bench/ucm_mode_status_tb.sv
`timescale 1ns/1ns
// ==========================================================================
// Bench for the mode registers and status flags.
module ucm_mode_status_tb;
  import ucm_pkg::*;
  logic SYS_CLK = 1'b0, NRST = 1'b0, rd = 1'b0, wr = 1'b0, snd = 1'b0, wreq;
  logic cts = 1'b1, rts;
  logic [4:0] adr = '0;
  logic [7:0] wd = '0, sd = '0, q;
  logic [31:0] rdata;
  ucm_tx_push_t pa;
  ucm_cfg_t ca, cb;
  ucm_rx_evt_t ea;
  ucm_tx_evt_t ta;
  int miscompares = 0, comparisons = 0, cyc = 0;
  // Free-running clock and a cycle ceiling against hangs.
  always #25 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report;
    end
  end
  ucm_mode_status ucm_mode_status_inst (.SYS_CLK(SYS_CLK), .NRST(NRST), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA({24'h0, wd}), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .RX_EVT_A(ea), .RX_EVT_B('0),
    .TX_EVT_A(ta), .TX_EVT_B('0), .CTS_N_A(cts), .CTS_N_B(1'b0), .TX_PUSH_A(pa),
    .TX_PUSH_B(), .CFG_A(ca), .CFG_B(cb), .GENERAL_OUTPUT_ZERO_N(rts), .GENERAL_OUTPUT_ONE_N());
  ucm_far_end ucm_far_end_inst (.clk(SYS_CLK), .nrst(NRST), .send(snd), .send_data(sd),
    .push_in(pa), .rx_evt(ea), .tx_evt(ta));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access, held until wait request is seen low at an edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge SYS_CLK); while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, a, 8'h00);
    cmp(q & m, e);
  endtask
  // Holds send high for n edges, so n characters arrive back to back.
  task automatic fill(input int n, input logic [7:0] d);
    @(posedge SYS_CLK);
    snd <= 1'b1;
    sd <= d;
    repeat (n) @(posedge SYS_CLK);
    snd <= 1'b0;
  endtask
  task automatic t_ptr;
    chk(5'h00, 8'h00, 8'hff);
    bus(1'b1, 5'h08, 8'hb0);
    bus(1'b1, 5'h00, 8'hff);
    bus(1'b1, 5'h00, 8'hde);
    bus(1'b1, 5'h00, 8'h3c);
    bus(1'b1, 5'h00, 8'h91);
    bus(1'b1, 5'h08, 8'hb0);
    chk(5'h00, 8'hf7, 8'hff);
    chk(5'h00, 8'hde, 8'hff);
    chk(5'h00, 8'h91, 8'hff);
    chk(5'h00, 8'h91, 8'hff);
    cmp({ca.baud_ext1, cb.baud_ext1, cb.baud_ext2, 5'h0}, 8'he0);
    cmp({ca.rx_timeout_en, 3'h0, ca.stop_len}, 8'h81);
    cmp({ca.loop_mode, ca.parity_mode, ca.error_mode, 1'b0, ca.char_len}, 8'hb2);
    cmp({7'h0, ca.parity_type}, 8'h01);
    bus(1'b1, 5'h18, 8'hb0);
    bus(1'b1, 5'h10, 8'hff);
    bus(1'b1, 5'h18, 8'hb0);
    chk(5'h10, 8'hf0, 8'hff);
    chk(5'h02, 8'h00, 8'hff);
    $display("pointer test done");
  endtask
  task automatic t_rx;
    bus(1'b1, 5'h08, 8'h05);
    fill(1, 8'ha5);
    chk(5'h04, 8'h01, 8'h03);
    chk(5'h0c, 8'ha5, 8'hff);
    chk(5'h04, 8'h00, 8'h01);
    fill(8, 8'h3c);
    chk(5'h04, 8'h03, 8'h03);
    cmp({6'h0, ca.rx_trig, ca.tx_trig}, 8'h03);
    cmp({7'h0, rts}, 8'h01);
    chk(5'h0c, 8'h3c, 8'hff);
    chk(5'h04, 8'h01, 8'h03);
    cmp({6'h0, ca.rx_trig, ca.tx_trig}, 8'h01);
    repeat (7) chk(5'h0c, 8'h3c, 8'hff);
    chk(5'h04, 8'h00, 8'h01);
    cmp({7'h0, rts}, 8'h00);
    $display("receive test done");
  endtask
  task automatic t_tx;
    chk(5'h04, 8'h04, 8'h04);
    cmp({7'h0, ca.tx_allow}, 8'h00);
    cts <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    cmp({7'h0, ca.tx_allow}, 8'h01);
    bus(1'b1, 5'h0c, 8'h77);
    chk(5'h04, 8'h00, 8'h08);
    repeat (20) @(posedge SYS_CLK);
    chk(5'h04, 8'h08, 8'h08);
    bus(1'b1, 5'h0c, 8'h55);
    chk(5'h04, 8'h00, 8'h08);
    repeat (20) @(posedge SYS_CLK);
    chk(5'h04, 8'h08, 8'h08);
    bus(1'b1, 5'h08, 8'h08);
    chk(5'h04, 8'h00, 8'h08);
    $display("transmit test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reset for five edges, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    t_ptr;
    t_rx;
    t_tx;
    final_report;
  end
endmodule // ucm_mode_status_tb
